// file: hdl/cpm_defines.vh
// Register map, field positions, reset values and codes of the clock path block
`ifndef CPM_DEFINES_VH
`define CPM_DEFINES_VH

// ************************************************************
// Register indices (byte address is four times the index)
// ************************************************************
`define CPM_IDX_PLL_CTRL       10'h010
`define CPM_IDX_CAL_CTRL       10'h018
`define CPM_IDX_DIV_SEL        10'h1E0
`define CPM_IDX_SRC_SEL        10'h1E1
`define CPM_IDX_UPDATE         10'h232
`define CPM_IDX_STATUS         10'h233

// ************************************************************
// Field positions
// ************************************************************
`define CPM_PLL_PWR_MSB        1
`define CPM_PLL_PWR_LSB        0
`define CPM_PLL_POL_BIT        7
`define CPM_CAL_BIT            0
`define CPM_DIV_MSB            2
`define CPM_DIV_LSB            0
`define CPM_BYP_BIT            0
`define CPM_SRC_BIT            1
`define CPM_UPD_BIT            0

// ************************************************************
// Codes and reset values
// ************************************************************
`define CPM_PWR_RUN            2'h0
`define CPM_PWR_DOWN           2'h1
`define CPM_RST_PLL_CTRL       8'h01
`define CPM_RST_CAL_CTRL       8'h00
`define CPM_RST_DIV_SEL        8'h02
`define CPM_RST_SRC_SEL        8'h00
`define CPM_RST_RATIO          3'h4
`define CPM_DIV_CODE_MAX       3'h4
`define CPM_DIV_OFFSET         3'h2
`define CPM_UPD_VALUE          8'h01

`endif

// file: hdl/cpm_avalon_slave.v
// Avalon-MM slave front end: decode and one-cycle waitrequest handshake
`timescale 1ns/100ps
module cpm_avalon_slave (
    input  wire        clock,
    input  wire        sys_rst,
    input  wire [11:0] avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [3:0]  avs_byteenable,
    input  wire [31:0] avs_writedata,
    output reg  [31:0] avs_readdata,
    output reg         avs_waitrequest,
    input  wire [31:0] rd_word,
    output wire [9:0]  acc_index,
    output wire        wr_pulse,
    output wire        rd_pulse
);

// ************************************************************
// Each access waits one cycle, then completes
// ************************************************************
reg done_reg;

assign acc_index = avs_address[11:2];
assign wr_pulse  = avs_write & done_reg & avs_byteenable[0];
assign rd_pulse  = avs_read & done_reg;

always @(posedge clock) begin
    if (sys_rst) begin
        done_reg        <= 1'b0;
        avs_waitrequest <= 1'b1;
        avs_readdata    <= 32'h0000_0000;
    end else begin
        // Waitrequest falls in the cycle after the request is seen
        if ((avs_read | avs_write) & ~done_reg) begin
            done_reg        <= 1'b1;
            avs_waitrequest <= 1'b0;
            avs_readdata    <= rd_word;
        end else begin
            done_reg        <= 1'b0;
            avs_waitrequest <= 1'b1;
        end
    end
end

endmodule

// file: hdl/cpm_clock_path.v
// Clock path mode configuration: staged registers, update strobe, active path controls
//
// Chosen here: the Avalon-MM slave port.
`timescale 1ns/100ps
`include "cpm_defines.vh"

// Notes on behaviour
// - Power code 01b powers the loop down through a registered output and 00b runs it.
// - After reset the loop is down, divide by four is used and the external input is the source.
// - The divider field picks ratio two to six, and code 010b gives four.
// - Bypass clear feeds distribution through the divider, set routes the source around it.
// - Source select clear picks the external input, set picks the internal oscillator.
// - Polarity bit zero means positive tuning slope and one means negative slope.
// - Written values stay staged until 0x01 is written to the update register.
// - With the external input selected, the internal oscillator stays powered down.
module cpm_clock_path (
    input  wire        clock,
    input  wire        sys_rst,
    input  wire [11:0] avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [3:0]  avs_byteenable,
    input  wire [31:0] avs_writedata,
    output wire [31:0] avs_readdata,
    output wire        avs_waitrequest,
    output reg         pll_power_down,
    output reg         pfd_polarity_neg,
    output reg  [2:0]  osc_div_ratio,
    output reg         div_bypass,
    output reg         src_internal_osc,
    output reg         osc_power_down,
    output reg         cal_run,
    output reg         cal_reset
);

// ************************************************************
// Staged and active register sets
// ************************************************************
reg  [7:0]  pll_ctrl_reg;
reg  [7:0]  cal_ctrl_reg;
reg  [7:0]  div_sel_reg;
reg  [7:0]  src_sel_reg;
reg  [7:0]  act_pll_reg;
reg  [7:0]  act_cal_reg;
reg  [7:0]  act_div_reg;
reg  [7:0]  act_src_reg;
reg         upd_pending_reg;
reg  [31:0] rd_word;
wire [9:0]  acc_index;
wire        wr_pulse;
wire        rd_pulse;
wire [7:0]  wbyte;
wire        do_update;
wire        upd_hit;
wire [7:0]  status_byte;

assign wbyte       = avs_writedata[7:0];
assign upd_hit     = (acc_index == `CPM_IDX_UPDATE);
assign do_update   = wr_pulse & upd_hit & (wbyte == `CPM_UPD_VALUE);
// Status shows the active copy, so software can tell staged from applied
assign status_byte = {act_src_reg[1:0], act_div_reg[2:0],
                      act_cal_reg[0], act_pll_reg[7], act_pll_reg[0]};

cpm_avalon_slave u_bus (
    .clock           (clock),
    .sys_rst         (sys_rst),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_byteenable  (avs_byteenable),
    .avs_writedata   (avs_writedata),
    .avs_readdata    (avs_readdata),
    .avs_waitrequest (avs_waitrequest),
    .rd_word         (rd_word),
    .acc_index       (acc_index),
    .wr_pulse        (wr_pulse),
    .rd_pulse        ()
);

// ************************************************************
// Staging writes
// ************************************************************
always @(posedge clock) begin
    if (sys_rst) begin
        pll_ctrl_reg <= `CPM_RST_PLL_CTRL;
        cal_ctrl_reg <= `CPM_RST_CAL_CTRL;
        div_sel_reg  <= `CPM_RST_DIV_SEL;
        src_sel_reg  <= `CPM_RST_SRC_SEL;
    end else if (wr_pulse) begin
        case (acc_index)
            `CPM_IDX_PLL_CTRL: begin
                pll_ctrl_reg <= wbyte;
            end
            `CPM_IDX_CAL_CTRL: begin
                cal_ctrl_reg <= wbyte;
            end
            `CPM_IDX_DIV_SEL: begin
                div_sel_reg  <= wbyte;
            end
            `CPM_IDX_SRC_SEL: begin
                src_sel_reg  <= wbyte;
            end
            default: ;
        endcase
    end
end

// ************************************************************
// Transfer to active settings on the update strobe
// ************************************************************
// The pending bit is visible for exactly one cycle; a read first seen in that
// cycle latches it since the bus samples read data on its first edge, so it reads one.
always @(posedge clock) begin
    if (sys_rst) begin
        act_pll_reg     <= `CPM_RST_PLL_CTRL;
        act_cal_reg     <= `CPM_RST_CAL_CTRL;
        act_div_reg     <= `CPM_RST_DIV_SEL;
        act_src_reg     <= `CPM_RST_SRC_SEL;
        upd_pending_reg <= 1'b0;
    end else begin
        upd_pending_reg <= do_update;
        if (upd_pending_reg) begin
            act_pll_reg <= pll_ctrl_reg;
            act_cal_reg <= cal_ctrl_reg;
            act_div_reg <= div_sel_reg;
            act_src_reg <= src_sel_reg;
        end
    end
end

// ************************************************************
// Read mux
// ************************************************************
always @* begin
    case (acc_index)
        `CPM_IDX_PLL_CTRL: begin
            rd_word = {24'h000000, pll_ctrl_reg};
        end
        `CPM_IDX_CAL_CTRL: begin
            rd_word = {24'h000000, cal_ctrl_reg};
        end
        `CPM_IDX_DIV_SEL: begin
            rd_word = {24'h000000, div_sel_reg};
        end
        `CPM_IDX_SRC_SEL: begin
            rd_word = {24'h000000, src_sel_reg};
        end
        `CPM_IDX_UPDATE: begin
            rd_word = {31'h00000000, upd_pending_reg};
        end
        `CPM_IDX_STATUS: begin
            rd_word = {24'h000000, status_byte};
        end
        default: begin
            rd_word = 32'h0000_0000;
        end
    endcase
end

// ************************************************************
// Next values of the path controls
// ************************************************************
wire [1:0]  pwr_code;
wire [2:0]  div_code;
wire        div_code_ok;
reg         pll_power_down_next;
reg         pfd_polarity_neg_next;
reg  [2:0]  osc_div_ratio_next;
reg         div_bypass_next;
reg         src_internal_osc_next;
reg         osc_power_down_next;
reg         cal_run_next;
reg         cal_reset_next;

assign pwr_code    = act_pll_reg[`CPM_PLL_PWR_MSB:`CPM_PLL_PWR_LSB];
assign div_code    = act_div_reg[`CPM_DIV_MSB:`CPM_DIV_LSB];
assign div_code_ok = (div_code <= `CPM_DIV_CODE_MAX);

always @* begin
    // Codes other than run leave the loop off, the safe choice
    pll_power_down_next   = (pwr_code != `CPM_PWR_RUN);
    pfd_polarity_neg_next = act_pll_reg[`CPM_PLL_POL_BIT];
    // Out-of-range codes hold the previous ratio rather than a bogus one
    osc_div_ratio_next    = osc_div_ratio;
    if (div_code_ok) begin
        osc_div_ratio_next = div_code + `CPM_DIV_OFFSET;
    end
    div_bypass_next       = act_src_reg[`CPM_BYP_BIT];
    src_internal_osc_next = act_src_reg[`CPM_SRC_BIT];
    // The oscillator draws no power while the external input feeds the path
    osc_power_down_next   = ~act_src_reg[`CPM_SRC_BIT];
    // A run request without the oscillator selected would calibrate nothing
    cal_run_next          = act_cal_reg[`CPM_CAL_BIT] & act_src_reg[`CPM_SRC_BIT];
    cal_reset_next        = ~act_cal_reg[`CPM_CAL_BIT];
end

// ************************************************************
// Active path controls, all registered
// ************************************************************
always @(posedge clock) begin
    if (sys_rst) begin
        pll_power_down   <= 1'b1;
        pfd_polarity_neg <= 1'b0;
        osc_div_ratio    <= `CPM_RST_RATIO;
        div_bypass       <= 1'b0;
        src_internal_osc <= 1'b0;
        osc_power_down   <= 1'b1;
        cal_run          <= 1'b0;
        cal_reset        <= 1'b1;
    end else begin
        pll_power_down   <= pll_power_down_next;
        pfd_polarity_neg <= pfd_polarity_neg_next;
        osc_div_ratio    <= osc_div_ratio_next;
        div_bypass       <= div_bypass_next;
        src_internal_osc <= src_internal_osc_next;
        osc_power_down   <= osc_power_down_next;
        cal_run          <= cal_run_next;
        cal_reset        <= cal_reset_next;
    end
end

endmodule

// file: bench/cpm_chk.sv
// Checker of the bus handshake and the staged update of the clock path block
`timescale 1ns/100ps
module cpm_chk (
    input logic        clock,
    input logic        sys_rst,
    input logic [11:0] avs_address,
    input logic        avs_read,
    input logic        avs_write,
    input logic [3:0]  avs_byteenable,
    input logic [31:0] avs_writedata,
    input logic [31:0] avs_readdata,
    input logic        avs_waitrequest,
    input logic        pll_power_down,
    input logic        pfd_polarity_neg,
    input logic [2:0]  osc_div_ratio,
    input logic        div_bypass,
    input logic        src_internal_osc,
    input logic        osc_power_down,
    input logic        cal_run,
    input logic        cal_reset
);
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    // ****************************************
    // Shadow of the staged registers
    // ****************************************
    logic       wr_hit;
    logic       upd_w;
    logic [7:0] pll_reg;
    logic [7:0] div_reg;
    logic [7:0] src_reg;
    assign wr_hit = avs_write && !avs_waitrequest && avs_byteenable[0];
    assign upd_w  = wr_hit && avs_address == 12'h8C8 && avs_writedata[7:0] == 8'h01;
    always @(posedge clock) begin
        if (sys_rst) begin
            pll_reg <= 8'h01;
            div_reg <= 8'h02;
            src_reg <= 8'h00;
        end else if (wr_hit) begin
            if (avs_address == 12'h040) pll_reg <= avs_writedata[7:0];
            if (avs_address == 12'h780) div_reg <= avs_writedata[7:0];
            if (avs_address == 12'h784) src_reg <= avs_writedata[7:0];
        end
    end
    // Pins load two edges after the update write and are seen at the third
    sequence upd_s;
        upd_w ##3 1'b1;
    endsequence
    wait_one_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("waitrequest not low after one wait");
    pwr_apply_a: assert property (upd_s |-> pll_power_down == ($past(pll_reg, 3) % 4 != 0))
        else $error("power state not applied");
    pol_apply_a: assert property (upd_s |-> pfd_polarity_neg == $past(pll_reg[7], 3))
        else $error("polarity not applied");
    div_apply_a: assert property (upd_s |-> ($past(div_reg[2:0], 3) > 3'h4)
        || (osc_div_ratio == $past(div_reg[2:0], 3) + 3'h2)) else $error("ratio wrong");
    path_apply_a: assert property (upd_s |-> {src_internal_osc, div_bypass}
        == $past(src_reg[1:0], 3)) else $error("path select not applied");
    stage_hold_a: assert property (!$past(upd_w, 3) |-> $stable(pll_power_down)
        && $stable(osc_div_ratio) && $stable(div_bypass)) else $error("staged value leaked");
    osc_off_a: assert property (osc_power_down != src_internal_osc)
        else $error("oscillator power wrong");
    cal_gate_a: assert property (cal_run |-> src_internal_osc && !cal_reset)
        else $error("calibration run without source");
    upd_zero_a: assert property (avs_read && !avs_waitrequest && avs_address == 12'h8C8
        |-> avs_readdata == 32'h0) else $error("update bit not cleared");
    rst_dflt_a: assert property ($fell(sys_rst) |-> pll_power_down && osc_div_ratio == 3'h4
        && !div_bypass && !src_internal_osc) else $error("reset defaults wrong");
endmodule

// file: bench/testbench.sv
// Self-checking bench for the clock path configuration block
`timescale 1ns/100ps
module testbench;
    logic        clock, sys_rst, avs_read, avs_write, avs_waitrequest;
    logic [11:0] avs_address;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_writedata, avs_readdata;
    logic        pll_power_down, pfd_polarity_neg, div_bypass, src_internal_osc;
    logic        osc_power_down, cal_run, cal_reset;
    logic [2:0]  osc_div_ratio;
    logic [7:0]  rd, pins;
    int          num_errors, tests_run, cycles;
    cpm_clock_path cpm_clock_path_inst (.*);
    assign pins = {pll_power_down, pfd_polarity_neg, div_bypass, src_internal_osc,
                   osc_power_down, cal_run, cal_reset, 1'b0};
    // ****************************************
    // Bus and compare tasks
    // ****************************************
    task automatic conclude();
        $display("errors=%0d checks=%0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One idle edge first, so a release and a new request never share a time step
    task automatic bus(input logic wr, input logic [11:0] a, input logic [7:0] d);
        @(posedge clock);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= {24'h0, d};
        do @(posedge clock); while (avs_waitrequest !== 1'b0);
        rd = avs_readdata[7:0];
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [7:0] exp);
        bus(1'b0, a, 8'h00);
        chk(rd, exp);
    endtask
    task automatic cfg(input logic [11:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
        bus(1'b1, 12'h8C8, 8'h01);
        repeat (3) @(posedge clock);
    endtask
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            conclude();
        end
    end
    initial begin
        {sys_rst, avs_read, avs_write, avs_address, avs_writedata} = {3'h4, 44'h0};
        avs_byteenable = 4'hF;
        repeat (10) @(posedge clock);
        sys_rst <= 1'b0;
        @(posedge clock);
        chk(pins, 8'h8A);
        chk({5'h0, osc_div_ratio}, 8'h04);
        rdchk(12'h040, 8'h01);
        rdchk(12'h780, 8'h02);
        rdchk(12'h784, 8'h00);
        bus(1'b1, 12'h004, 8'h5A);
        rdchk(12'h004, 8'h00);
        bus(1'b1, 12'h040, 8'h80);
        bus(1'b1, 12'h8C8, 8'h02);
        repeat (3) @(posedge clock);
        chk(pins, 8'h8A);
        rdchk(12'h040, 8'h80);
        cfg(12'h060, 8'h00);
        chk(pins, 8'h4A);
        rdchk(12'h8C8, 8'h00);
        for (int c = 0; c < 5; c++) begin
            cfg(12'h780, 8'(c));
            chk({5'h0, osc_div_ratio}, 8'(c + 2));
        end
        cfg(12'h784, 8'h02);
        chk(pins, 8'h52);
        cfg(12'h060, 8'h01);
        chk(pins, 8'h54);
        cfg(12'h060, 8'h00);
        chk(pins, 8'h52);
        cfg(12'h060, 8'h01);
        chk(pins, 8'h54);
        cfg(12'h060, 8'h00);
        cfg(12'h040, 8'h01);
        chk(pins, 8'h92);
        rdchk(12'h8CC, 8'hA1);
        // A write with lane 0 disabled must leave the staged byte alone
        avs_byteenable <= 4'hE;
        bus(1'b1, 12'h784, 8'h01);
        avs_byteenable <= 4'hF;
        rdchk(12'h784, 8'h02);
        cfg(12'h784, 8'h01);
        chk(pins, 8'hAA);
        cfg(12'h784, 8'h00);
        chk(pins, 8'h8A);
        conclude();
    end
endmodule
bind cpm_clock_path cpm_chk cpm_chk_inst (.*);
